/* core/ctr_pkg.sv */
// Shared constants and types of the calibration and trim register bank.
package ctr_pkg;
	// ----------------------------------------
	// Register geometry
	// ----------------------------------------
	localparam int CTR_CAL_W = 110;
	localparam int CTR_TRIM_W = 20;
	localparam int CTR_CONST_W = 11;
	localparam int CTR_NCONST = 10;
	localparam logic [6:0] CTR_CAL_LEN = 7'h6e;
	localparam logic [6:0] CTR_TRIM_LEN = 7'h14;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CTR_CUR_IDX0 = 0;
	localparam int CTR_VOLT_IDX0 = 4;
	localparam int CTR_TRC_LSB = 15;
	localparam int CTR_TRA_LSB = 10;
	localparam int CTR_TRV_LSB = 5;
	localparam int CTR_TRT_LSB = 0;
	localparam int CTR_FLD_W = 5;
	// ----------------------------------------
	// Reset values and fixed codes
	// ----------------------------------------
	localparam logic [10:0] CTR_CONST_RESET = 11'h60c;
	localparam logic [109:0] CTR_CAL_RESET = {CTR_NCONST{CTR_CONST_RESET}};
	localparam logic [19:0] CTR_TRIM_RESET = 20'h00000;
	localparam logic [3:0] CTR_MODE_WRITE = 4'h8;
	localparam logic [2:0] CTR_VSEL_FIXED = 3'h6;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {
		CTR_ST_LOAD = 3'b001,
		CTR_ST_IDLE = 3'b010,
		CTR_ST_SHIFT = 3'b100
	} ctr_state_t;
	typedef struct packed {
		logic signed [5:0] cur_steps;
		logic signed [5:0] amp_steps;
		logic signed [5:0] lvl_steps;
		logic signed [5:0] tc_steps;
	} ctr_trim_steps_t;
	typedef struct packed {
		logic current_sense_select;
		logic [1:0] gain_sel;
		logic [2:0] voltage_const_sel;
	} ctr_sel_t;
endpackage

/* core/ctr_calibration_trim_registers.sv */
// Calibration constant and analog trim register bank with serial access.
`timescale 1ns/1ps
module ctr_calibration_trim_registers (
	// Clock and reset
	input wire logic clk_in,
	input wire logic srst_in,
	// Fuse storage load
	input wire logic fuse_valid_in,
	input wire logic [109:0] fuse_calibration_field_in,
	input wire logic [19:0] fuse_trim_field_in,
	// Operating mode
	input wire logic [3:0] mode_in,
	// Serial register transfer
	input wire logic xfer_start_in,
	input wire logic xfer_read_in,
	input wire logic xfer_trim_in,
	input wire logic xfer_abort_in,
	input wire logic bit_strobe_in,
	input wire logic bit_in,
	output logic bit_out,
	output logic xfer_busy_out,
	// Constant selection for the correction path
	input ctr_pkg::ctr_sel_t sel_in,
	output logic [10:0] cal_const_out,
	output logic cal_ready_out,
	// Register contents and decoded trims
	output logic [109:0] calibration_constants_out,
	output logic [19:0] analog_trim_codes_out,
	output ctr_pkg::ctr_trim_steps_t trim_steps_out
);
	import ctr_pkg::*;

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	// Sign-magnitude code to signed step count.
	function automatic logic signed [5:0] sm_steps(input logic [4:0] code);
		logic signed [5:0] mag;
		mag = signed'({2'b00, code[3:0]});
		return code[4] ? mag : -mag;
	endfunction

	// Current source code: 0..15 lower by code, 16..31 raise by 32 minus code.
	function automatic logic signed [5:0] cur_steps(input logic [4:0] code);
		logic [5:0] up;
		up = 6'h20 - {1'b0, code};
		return code[4] ? signed'(up) : -signed'({1'b0, code});
	endfunction

	function automatic logic [10:0] const_at(input logic [109:0] cal, input int idx);
		return cal[CTR_CAL_W - 1 - idx * CTR_CONST_W -: CTR_CONST_W];
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	ctr_state_t state_q, state_d;
	logic [109:0] cal_q, cal_d;
	logic [19:0] trim_q, trim_d;
	logic [109:0] shift_q, shift_d;
	logic [6:0] cnt_q, cnt_d;
	logic rd_q, rd_d;
	logic sel_trim_q, sel_trim_d;
	logic [6:0] len;
	logic last_bit;

	assign len = sel_trim_q ? CTR_TRIM_LEN : CTR_CAL_LEN;
	assign last_bit = bit_strobe_in && (cnt_q == len - 7'h01);

	// ----------------------------------------
	// Load and transfer sequencing
	// ----------------------------------------
	always_comb begin
		state_d = state_q;
		cal_d = cal_q;
		trim_d = trim_q;
		shift_d = shift_q;
		cnt_d = cnt_q;
		rd_d = rd_q;
		sel_trim_d = sel_trim_q;
		unique case (state_q)
			CTR_ST_LOAD: begin
				if (fuse_valid_in) begin
					cal_d = fuse_calibration_field_in;
					trim_d = fuse_trim_field_in;
					state_d = CTR_ST_IDLE;
				end
			end
			CTR_ST_IDLE: begin
				if (xfer_start_in) begin
					rd_d = xfer_read_in;
					sel_trim_d = xfer_trim_in;
					cnt_d = 7'h00;
					// Read data is left aligned so the MSB leaves first.
					shift_d = xfer_trim_in ? {trim_q, 90'h0} : cal_q;
					state_d = CTR_ST_SHIFT;
				end
			end
			CTR_ST_SHIFT: begin
				if (xfer_abort_in) begin
					state_d = CTR_ST_IDLE;
				end else if (bit_strobe_in) begin
					// MSB first in both directions.
					shift_d = rd_q ? {shift_q[108:0], 1'b0} : {shift_q[108:0], bit_in};
					cnt_d = cnt_q + 7'h01;
					if (last_bit) begin
						state_d = CTR_ST_IDLE;
						if (!rd_q && mode_in == CTR_MODE_WRITE) begin
							if (sel_trim_q) begin
								trim_d = {shift_q[18:0], bit_in};
							end else begin
								cal_d = {shift_q[108:0], bit_in};
							end
						end
					end
				end
			end
			default: begin
				state_d = CTR_ST_LOAD;
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			state_q <= CTR_ST_LOAD;
			cal_q <= CTR_CAL_RESET;
			trim_q <= CTR_TRIM_RESET;
			shift_q <= '0;
			cnt_q <= 7'h00;
			rd_q <= 1'b0;
			sel_trim_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cal_q <= cal_d;
			trim_q <= trim_d;
			shift_q <= shift_d;
			cnt_q <= cnt_d;
			rd_q <= rd_d;
			sel_trim_q <= sel_trim_d;
		end
	end

	// ----------------------------------------
	// Constant selection and trim decode
	// ----------------------------------------
	logic [10:0] const_d;
	ctr_trim_steps_t steps_d;
	logic bit_d;

	always_comb begin
		if (sel_in.current_sense_select) begin
			const_d = const_at(cal_q, CTR_CUR_IDX0 + int'(sel_in.gain_sel));
		end else if (sel_in.voltage_const_sel >= CTR_VSEL_FIXED) begin
			const_d = CTR_CONST_RESET;
		end else begin
			const_d = const_at(cal_q, CTR_VOLT_IDX0 + int'(sel_in.voltage_const_sel));
		end
		steps_d.cur_steps = cur_steps(trim_q[CTR_TRC_LSB +: CTR_FLD_W]);
		steps_d.amp_steps = sm_steps(trim_q[CTR_TRA_LSB +: CTR_FLD_W]);
		steps_d.lvl_steps = sm_steps(trim_q[CTR_TRV_LSB +: CTR_FLD_W]);
		steps_d.tc_steps = sm_steps(trim_q[CTR_TRT_LSB +: CTR_FLD_W]);
		bit_d = (state_q == CTR_ST_SHIFT) && rd_q && shift_q[109];
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			cal_const_out <= CTR_CONST_RESET;
			cal_ready_out <= 1'b0;
			trim_steps_out <= '0;
			bit_out <= 1'b0;
			xfer_busy_out <= 1'b0;
			calibration_constants_out <= CTR_CAL_RESET;
			analog_trim_codes_out <= CTR_TRIM_RESET;
		end else begin
			cal_const_out <= const_d;
			cal_ready_out <= (state_q != CTR_ST_LOAD);
			trim_steps_out <= steps_d;
			bit_out <= bit_d;
			xfer_busy_out <= (state_d == CTR_ST_SHIFT);
			calibration_constants_out <= cal_d;
			analog_trim_codes_out <= trim_d;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (srst_in);

	sequence s_write_last;
		(state_q == CTR_ST_SHIFT) && !rd_q && !xfer_abort_in && last_bit && (mode_in == CTR_MODE_WRITE);
	endsequence

	sequence s_fuse_load;
		(state_q == CTR_ST_LOAD) && fuse_valid_in;
	endsequence

	sequence s_start_taken;
		(state_q == CTR_ST_IDLE) && xfer_start_in;
	endsequence

	sequence s_abort_taken;
		(state_q == CTR_ST_SHIFT) && xfer_abort_in;
	endsequence

	sequence s_read_start;
		(state_q == CTR_ST_IDLE) && xfer_start_in && xfer_read_in;
	endsequence

	chk_cal_default: assert property ($past(srst_in) |-> cal_q == CTR_CAL_RESET && trim_q == CTR_TRIM_RESET)
		else $error("Register defaults wrong after reset.");
	chk_fuse_copy: assert property (s_fuse_load |=> cal_q == $past(fuse_calibration_field_in))
		else $error("Fuse calibration field not copied.");
	chk_fuse_trim: assert property (s_fuse_load |=> trim_q == $past(fuse_trim_field_in) ##1 cal_ready_out)
		else $error("Fuse trim field not loaded.");
	chk_cur_select: assert property (sel_in.current_sense_select
		|=> cal_const_out == const_at($past(cal_q), CTR_CUR_IDX0 + int'($past(sel_in.gain_sel))))
		else $error("Current constant not taken from register.");
	chk_fixed_sel: assert property (!sel_in.current_sense_select && sel_in.voltage_const_sel[2:1] == 2'b11
		|=> cal_const_out == CTR_CONST_RESET)
		else $error("Fixed constant not used for selector 6 or 7.");
	chk_write_commit: assert property ((s_write_last and !sel_trim_q)
		|=> cal_q == {$past(shift_q[108:0]), $past(bit_in)})
		else $error("Calibration write not committed.");
	chk_trim_commit: assert property ((s_write_last and sel_trim_q)
		|=> trim_q == {$past(shift_q[18:0]), $past(bit_in)})
		else $error("Trim write not committed.");
	chk_mode_block: assert property (state_q != CTR_ST_LOAD && mode_in != CTR_MODE_WRITE
		|=> $stable(cal_q) && $stable(trim_q))
		else $error("Write accepted outside mode 8.");
	chk_short_keep: assert property (state_q != CTR_ST_LOAD && !last_bit |=> $stable(cal_q) && $stable(trim_q))
		else $error("Register changed before full length.");
	chk_amp_decode: assert property (1'b1
		|=> trim_steps_out.amp_steps == ($past(trim_q[CTR_TRA_LSB + 4]) ? {2'b00, $past(trim_q[CTR_TRA_LSB +: 4])}
		: 6'h00 - {2'b00, $past(trim_q[CTR_TRA_LSB +: 4])}))
		else $error("Offset trim decode wrong.");
	chk_cur_decode: assert property (trim_q[19:15] == 5'h10 |=> trim_steps_out.cur_steps == 6'sd16)
		else $error("Current trim code 16 not full raise.");

	// ----------------------------------------
	// Transfer checks
	// ----------------------------------------
	chk_busy_start: assert property (s_start_taken
		|=> xfer_busy_out && (state_q == CTR_ST_SHIFT))
		else $error("Transfer start not taken.");
	chk_count_clear: assert property (s_start_taken
		|=> cnt_q == 7'h00)
		else $error("Bit counter not cleared at start.");
	chk_abort_idle: assert property (s_abort_taken
		|=> !xfer_busy_out && $stable(cal_q) && $stable(trim_q))
		else $error("Aborted transfer changed a register.");
	chk_read_msb: assert property ((s_read_start and !xfer_trim_in)
		|=> ##1 bit_out == $past(cal_q[109], 2))
		else $error("Calibration read does not begin with the top bit.");
	chk_trim_msb: assert property ((s_read_start and xfer_trim_in)
		|=> ##1 bit_out == $past(trim_q[19], 2))
		else $error("Trim read does not begin with the top bit.");
	chk_read_keep: assert property ((state_q == CTR_ST_SHIFT) && rd_q
		|=> $stable(cal_q) && $stable(trim_q))
		else $error("Read transfer changed a register.");
	chk_bit_idle: assert property ((state_q != CTR_ST_SHIFT) || !rd_q
		|=> !bit_out)
		else $error("Read data line not low outside reads.");
	chk_load_wait: assert property ((state_q == CTR_ST_LOAD)
		|-> !cal_ready_out && !xfer_busy_out)
		else $error("Register used before fuse load.");
	chk_ready_hold: assert property (cal_ready_out
		|=> cal_ready_out)
		else $error("Ready dropped without reset.");
	chk_fuse_once: assert property ((state_q != CTR_ST_LOAD)
		|=> state_q != CTR_ST_LOAD)
		else $error("Fuse load repeated without reset.");

	// ----------------------------------------
	// Decode checks
	// ----------------------------------------
	chk_volt_select: assert property (!sel_in.current_sense_select
		&& (sel_in.voltage_const_sel < CTR_VSEL_FIXED)
		|=> cal_const_out == const_at($past(cal_q), CTR_VOLT_IDX0 + int'($past(sel_in.voltage_const_sel))))
		else $error("Voltage constant not taken from register.");
	chk_lvl_raise: assert property (trim_q[CTR_TRV_LSB + 4]
		|=> trim_steps_out.lvl_steps == {2'b00, $past(trim_q[CTR_TRV_LSB +: 4])})
		else $error("Level trim raise decode wrong.");
	chk_tc_lower: assert property (!trim_q[CTR_TRT_LSB + 4]
		|=> trim_steps_out.tc_steps == 6'h00 - {2'b00, $past(trim_q[CTR_TRT_LSB +: 4])})
		else $error("Coefficient trim lower decode wrong.");
	chk_cur_lower: assert property (!trim_q[CTR_TRC_LSB + 4]
		|=> trim_steps_out.cur_steps == 6'h00 - {1'b0, $past(trim_q[CTR_TRC_LSB +: 5])})
		else $error("Current trim lower decode wrong.");
endmodule

/* sim/ctr_mcu_model.sv */
// Serial master model that drives register transfers into the bank.
`timescale 1ns/1ps
module ctr_mcu_model (
	// Clock and device read data
	input wire logic clk_in,
	input wire logic dev_bit_in,
	// Transfer controls
	output logic xfer_start_out,
	output logic xfer_read_out,
	output logic xfer_trim_out,
	output logic xfer_abort_out,
	output logic bit_strobe_out,
	output logic bit_out
);
	initial begin
		{xfer_start_out, xfer_read_out, xfer_trim_out, xfer_abort_out, bit_strobe_out, bit_out} = '0;
	end
	task automatic xfer(input logic rd, input logic tr, input logic [109:0] wd, input int len, input int stop,
		output logic [109:0] rq);
		rq = '0;
		xfer_read_out = rd;
		xfer_trim_out = tr;
		xfer_start_out = 1'b1;
		@(posedge clk_in);
		#1;
		xfer_start_out = 1'b0;
		if (rd) begin
			@(posedge clk_in);
			#1;
		end
		for (int i = 0; i < len; i++) begin
			if (i == stop) begin
				bit_strobe_out = 1'b0;
				xfer_abort_out = 1'b1;
				@(posedge clk_in);
				#1;
				xfer_abort_out = 1'b0;
				break;
			end
			bit_out = wd[len - 1 - i];
			bit_strobe_out = 1'b1;
			@(posedge clk_in);
			#1;
			rq = {rq[108:0], dev_bit_in};
		end
		bit_strobe_out = 1'b0;
		bit_out = ~bit_out;
	endtask
endmodule

/* sim/tb_top.sv */
// Self-checking bench for the calibration and trim register bank.
`timescale 1ns/1ps
module tb_top;
	import ctr_pkg::*;
	logic clk_in = 1'b0;
	logic srst_in = 1'b1;
	logic fuse_valid_in = 1'b0;
	logic [109:0] fuse_cal = '0;
	logic [19:0] fuse_trim = 20'h5a3c1;
	logic [3:0] mode_in = 4'h0;
	logic start, rd, tr, abort, strobe, wbit, bit_out, busy, ready;
	ctr_sel_t sel_in = '0;
	logic [10:0] cal_const;
	logic [109:0] cal_q, rdat;
	logic [19:0] trim_q;
	ctr_trim_steps_t steps;
	logic [5:0] row_sel [12] = '{6'h20, 6'h2f, 6'h30, 6'h38, 6'h18, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07};
	logic [3:0] row_idx [12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'ha};
	int mismatches = 0;
	int samples_checked = 0;
	always #20 clk_in = ~clk_in;
	ctr_calibration_trim_registers dut (.clk_in(clk_in), .srst_in(srst_in), .fuse_valid_in(fuse_valid_in),
		.fuse_calibration_field_in(fuse_cal), .fuse_trim_field_in(fuse_trim), .mode_in(mode_in),
		.xfer_start_in(start), .xfer_read_in(rd), .xfer_trim_in(tr), .xfer_abort_in(abort),
		.bit_strobe_in(strobe), .bit_in(wbit), .bit_out(bit_out), .xfer_busy_out(busy), .sel_in(sel_in),
		.cal_const_out(cal_const), .cal_ready_out(ready), .calibration_constants_out(cal_q),
		.analog_trim_codes_out(trim_q), .trim_steps_out(steps));
	ctr_mcu_model m (.clk_in(clk_in), .dev_bit_in(bit_out), .xfer_start_out(start), .xfer_read_out(rd),
		.xfer_trim_out(tr), .xfer_abort_out(abort), .bit_strobe_out(strobe), .bit_out(wbit));
	task automatic chk(input string nm, input logic [109:0] seen, input logic [109:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic run_sel(input logic [109:0] c);
		for (int r = 0; r < 12; r++) begin
			sel_in = row_sel[r];
			@(posedge clk_in);
			#1;
			chk("cal_const", cal_const, (row_idx[r] > 9) ? CTR_CONST_RESET : c[109 - 11 * row_idx[r] -: 11]);
		end
		$display("selection test done");
	endtask
	initial begin
		#(40 * 4000);
		mismatches++;
		end_of_test();
	end
	initial begin
		for (int i = 0; i < 10; i++) fuse_cal[109 - 11 * i -: 11] = 11'h0a0 + 11'(i);
		repeat (12) @(posedge clk_in);
		#1;
		chk("cal reset", cal_q, CTR_CAL_RESET);
		chk("trim reset", trim_q, '0);
		srst_in = 1'b0;
		@(posedge clk_in);
		#1;
		fuse_valid_in = 1'b1;
		@(posedge clk_in);
		#1;
		fuse_valid_in = 1'b0;
		@(posedge clk_in);
		#1;
		chk("cal fuse", cal_q, fuse_cal);
		chk("trim fuse", trim_q, 20'h5a3c1);
		chk("ready", ready, 1'b1);
		$display("fuse load test done");
		run_sel(fuse_cal);
		mode_in = CTR_MODE_WRITE;
		m.xfer(1'b0, 1'b0, ~fuse_cal, 110, 999, rdat);
		chk("cal write", cal_q, ~fuse_cal);
		chk("busy", busy, 1'b0);
		run_sel(~fuse_cal);
		mode_in = 4'h0;
		m.xfer(1'b1, 1'b0, '0, 110, 999, rdat);
		chk("cal read", rdat, ~fuse_cal);
		mode_in = CTR_MODE_WRITE;
		m.xfer(1'b0, 1'b1, 110'h88ff0, 20, 999, rdat);
		chk("trim write", trim_q, 20'h88ff0);
		@(posedge clk_in);
		#1;
		chk("trim steps", steps, {6'h0f, 6'h3d, 6'h0f, 6'h00});
		m.xfer(1'b1, 1'b1, '0, 20, 999, rdat);
		chk("trim read", rdat, 20'h88ff0);
		mode_in = 4'h7;
		m.xfer(1'b0, 1'b1, 110'h12345, 20, 999, rdat);
		chk("trim locked", trim_q, 20'h88ff0);
		mode_in = CTR_MODE_WRITE;
		m.xfer(1'b0, 1'b1, 110'h00003, 20, 999, rdat);
		chk("tc first", trim_q, 20'h00003);
		m.xfer(1'b0, 1'b1, 110'h04a83, 20, 999, rdat);
		chk("level after tc", trim_q, 20'h04a83);
		@(posedge clk_in);
		#1;
		chk("trim steps signs", steps, {6'h00, 6'h02, 6'h04, 6'h3d});
		$display("trim order test done");
		m.xfer(1'b0, 1'b0, fuse_cal, 110, 109, rdat);
		chk("cal abort", cal_q, ~fuse_cal);
		$display("transfer tests done");
		srst_in = 1'b1;
		repeat (2) @(posedge clk_in);
		#1;
		chk("cal rereset", cal_q, CTR_CAL_RESET);
		chk("trim rereset", trim_q, '0);
		chk("ready rereset", ready, 1'b0);
		chk("const rereset", cal_const, CTR_CONST_RESET);
		chk("steps rereset", steps, '0);
		srst_in = 1'b0;
		fuse_valid_in = 1'b1;
		@(posedge clk_in);
		#1;
		fuse_valid_in = 1'b0;
		@(posedge clk_in);
		#1;
		chk("cal reload", cal_q, fuse_cal);
		chk("trim reload", trim_q, 20'h5a3c1);
		chk("ready reload", ready, 1'b1);
		$display("second reset test done");
		end_of_test();
	end
endmodule
